// [core/cigen_access_route.sv]
// trap and virtual-redirect decision for one group enable encoding
// assumes the access level and security state are stable with the request
`timescale 1ns/1ps
module cigen_access_route #(
  parameter bit HAS_EL3 = 1'b1
) (
  input wire cigen_pkg::cigen_el_t el,
  input wire logic ns,
  input wire logic [2:0] sysreg_interface_enable,
  input wire logic trapAll,
  input wire logic scrRoute,
  input wire logic hypRoute,
  output cigen_pkg::cigen_route_s route
);

  logic sreHere;

  always_comb begin
    case (el)
      cigen_pkg::EL_1: sreHere = sysreg_interface_enable[0];
      cigen_pkg::EL_2: sreHere = sysreg_interface_enable[1];
      cigen_pkg::EL_3: sreHere = sysreg_interface_enable[2];
      default: sreHere = 1'b0;
    endcase
  end

  always_comb begin
    route = '0;
    if (el == cigen_pkg::EL_0) begin
      // no access from the lowest level
      route.trap = 1'b1;
      route.trapEl = cigen_pkg::EL_1;
    // R13 interface enable trap
    end else if (!sreHere) begin
      route.trap = 1'b1;
      route.trapEl = el;
    // R14 R15 trap to hypervisor
    end else if (ns && el == cigen_pkg::EL_1 && trapAll) begin
      route.trap = 1'b1;
      route.trapEl = cigen_pkg::EL_2;
    // R16 R17 trap to top level
    end else if (HAS_EL3 && scrRoute &&
                 ((el == cigen_pkg::EL_1 && (!ns || !hypRoute)) || el == cigen_pkg::EL_2)) begin
      route.trap = 1'b1;
      route.trapEl = cigen_pkg::EL_3;
    // R10 R11 virtual redirect
    end else if (ns && el == cigen_pkg::EL_1 && hypRoute) begin
      route.virt = 1'b1;
    end
  end

endmodule

// [core/cigen_group_enable_regs.sv]
// group 0 and group 1 interrupt enable registers of one cpu interface
// assumes the core presents one system-register access per cycle, answered next cycle
//
// Contract
// R01 - group-0 enable is bit 0; bits 31:1 read as zero
// R02 - group-1 enable bit enables group 1 for current security state
// R03 - both enable bits reset to zero
// R04 - virtual group-0 accesses update the virtual group-0 field only
// R05 - virtual group-1 accesses update the virtual group-1 field only
// R06 - group-0 enable falling retargets a pending 1-of-N group-0 interrupt
// R07 - group-1 enable falling retargets a pending 1-of-N group-1 interrupt
// R08 - secure and non-secure group-1 copies alias top-level enable bits
// R09 - top-level access to group-1 enable picks copy by non-secure bit
// R10 - hypervisor fast routing sends non-secure EL1 group-0 accesses to virtual
// R11 - hypervisor normal routing sends non-secure EL1 group-1 accesses to virtual
// R12 - both registers read and written by system-register encodings given
// R13 - interface enable clear traps accesses to the same level
// R14 - trap-all-group0 traps non-secure EL1 group-0 accesses to EL2
// R15 - trap-all-group1 traps non-secure EL1 group-1 accesses to EL2
// R16 - secure fast routing traps group-0 accesses to EL3
// R17 - secure normal routing traps group-1 accesses to EL3
// R18 - disabled group is not signalled; signalling resumes when re-enabled
`timescale 1ns/1ps
module cigen_group_enable_regs #(
  parameter bit HAS_EL3 = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reqValid,
  input wire cigen_pkg::cigen_req_s req,
  input wire cigen_pkg::cigen_ctrl_s ctrl,
  input wire logic hppiValid,
  input wire logic hppiGroup1,
  input wire logic hppiSecure,
  input wire logic hppiOneOfN,
  input wire logic pendGroup0,
  input wire logic pendGroup1,
  output logic rspValid,
  output cigen_pkg::cigen_rsp_s rsp,
  output logic group0Enable,
  output logic secureGroup1EnBit,
  output logic nonsecureGroup1EnBit,
  output logic virtGroup0EnField,
  output logic virtGroup1EnField,
  output logic fiqSignal,
  output logic irqSignal,
  output logic retargetGroup0,
  output logic retargetGroup1
);

  logic hitG0;
  logic hitG1;
  logic hitTop;
  logic ns;
  logic wrBit;
  cigen_pkg::cigen_route_s route0;
  cigen_pkg::cigen_route_s route1;
  cigen_pkg::cigen_route_s routeTop;
  cigen_pkg::cigen_route_s routeSel;
  logic physWrG0;
  logic physWrG1;
  logic physWrTop;
  logic virtWrG0;
  logic virtWrG1;
  logic curGroup1;
  logic retarget1S;
  logic retarget1NS;
  logic [31:0] next_rdata;

  assign ns = ctrl.nonsecureStateBit;
  assign wrBit = req.wdata[cigen_pkg::ENABLE_POS];

  // R12 encoding decode
  assign hitG0 = req.enc == cigen_pkg::ENC_GROUP0;
  assign hitG1 = req.enc == cigen_pkg::ENC_GROUP1;
  assign hitTop = req.enc == cigen_pkg::ENC_TOP_GROUP1;

  cigen_access_route #(.HAS_EL3(HAS_EL3)) u_route0 (
    .el(req.el),
    .ns(ns),
    .sysreg_interface_enable(ctrl.sysregInterfaceEnable),
    .trapAll(ctrl.trapAllGroup0),
    .scrRoute(ctrl.secureFastIrqRouting),
    .hypRoute(ctrl.hypFastIrqRouting),
    .route(route0)
  );

  cigen_access_route #(.HAS_EL3(HAS_EL3)) u_route1 (
    .el(req.el),
    .ns(ns),
    .sysreg_interface_enable(ctrl.sysregInterfaceEnable),
    .trapAll(ctrl.trapAllGroup1),
    .scrRoute(ctrl.secureNormalIrqRouting),
    .hypRoute(ctrl.hypNormalIrqRouting),
    .route(route1)
  );

  // top-level register: only EL3 with its interface enabled
  always_comb begin
    routeTop = '0;
    if (req.el != cigen_pkg::EL_3) begin
      routeTop.trap = 1'b1;
      routeTop.trapEl = cigen_pkg::EL_1;
    end else if (!ctrl.sysregInterfaceEnable[2]) begin
      routeTop.trap = 1'b1;
      routeTop.trapEl = cigen_pkg::EL_3;
    end
  end

  always_comb begin
    routeSel = '0;
    if (hitG0) begin
      routeSel = route0;
    end else if (hitG1) begin
      routeSel = route1;
    end else if (hitTop) begin
      routeSel = routeTop;
    end else begin
      // unknown encoding is undefined at EL1
      routeSel.trap = 1'b1;
      routeSel.trapEl = cigen_pkg::EL_1;
    end
  end

  assign physWrG0 = reqValid && req.write && hitG0 && !route0.trap && !route0.virt;
  assign physWrG1 = reqValid && req.write && hitG1 && !route1.trap && !route1.virt;
  assign physWrTop = reqValid && req.write && hitTop && !routeTop.trap;
  assign virtWrG0 = reqValid && req.write && hitG0 && route0.virt;
  assign virtWrG1 = reqValid && req.write && hitG1 && route1.virt;

  // R01 R03 group-0 enable
  always_ff @(posedge clk) begin
    if (srst) begin
      group0Enable <= cigen_pkg::ENABLE_RESET;
    end else if (physWrG0) begin
      group0Enable <= wrBit;
    end
  end

  // R08 R09 banked group-1 copies
  always_ff @(posedge clk) begin
    if (srst) begin
      secureGroup1EnBit <= cigen_pkg::ENABLE_RESET;
      nonsecureGroup1EnBit <= cigen_pkg::ENABLE_RESET;
    end else if (physWrTop) begin
      secureGroup1EnBit <= req.wdata[cigen_pkg::TOP_S_POS];
      nonsecureGroup1EnBit <= req.wdata[cigen_pkg::TOP_NS_POS];
    end else if (physWrG1) begin
      if (ns) begin
        nonsecureGroup1EnBit <= wrBit;
      end else begin
        secureGroup1EnBit <= wrBit;
      end
    end
  end

  // R04 R05 virtual fields
  always_ff @(posedge clk) begin
    if (srst) begin
      virtGroup0EnField <= cigen_pkg::ENABLE_RESET;
      virtGroup1EnField <= cigen_pkg::ENABLE_RESET;
    end else begin
      if (virtWrG0) begin
        virtGroup0EnField <= wrBit;
      end
      if (virtWrG1) begin
        virtGroup1EnField <= wrBit;
      end
    end
  end

  // R02 copy of the running security state
  assign curGroup1 = ns ? nonsecureGroup1EnBit : secureGroup1EnBit;

  always_comb begin
    next_rdata = cigen_pkg::RDATA_ZERO;
    if (!routeSel.trap) begin
      if (hitG0) begin
        next_rdata[cigen_pkg::ENABLE_POS] = routeSel.virt ? virtGroup0EnField : group0Enable;
      end else if (hitG1) begin
        next_rdata[cigen_pkg::ENABLE_POS] = routeSel.virt ? virtGroup1EnField : curGroup1;
      end else if (hitTop) begin
        next_rdata[cigen_pkg::TOP_S_POS] = secureGroup1EnBit;
        next_rdata[cigen_pkg::TOP_NS_POS] = nonsecureGroup1EnBit;
      end
    end
  end

  // response one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      rspValid <= 1'b0;
      rsp <= '0;
    end else begin
      rspValid <= reqValid;
      if (reqValid) begin
        rsp.trap <= routeSel.trap;
        rsp.trapEl <= routeSel.trapEl;
        rsp.virt <= routeSel.virt;
        rsp.rdata <= req.write ? cigen_pkg::RDATA_ZERO : next_rdata;
      end
    end
  end

  // R18 group gating of signals
  always_ff @(posedge clk) begin
    if (srst) begin
      fiqSignal <= 1'b0;
      irqSignal <= 1'b0;
    end else begin
      fiqSignal <= pendGroup0 && group0Enable;
      irqSignal <= pendGroup1 && curGroup1;
    end
  end

  cigen_retarget u_ret0 (
    .clk(clk),
    .srst(srst),
    .enable(group0Enable),
    .hppiMatch(hppiValid && !hppiGroup1 && hppiOneOfN),
    .retarget(retargetGroup0)
  );

  cigen_retarget u_ret1s (
    .clk(clk),
    .srst(srst),
    .enable(secureGroup1EnBit),
    .hppiMatch(hppiValid && hppiGroup1 && hppiSecure && hppiOneOfN),
    .retarget(retarget1S)
  );

  cigen_retarget u_ret1ns (
    .clk(clk),
    .srst(srst),
    .enable(nonsecureGroup1EnBit),
    .hppiMatch(hppiValid && hppiGroup1 && !hppiSecure && hppiOneOfN),
    .retarget(retarget1NS)
  );

  assign retargetGroup1 = retarget1S || retarget1NS;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_reset_clears_enables: assert property ($past(srst) |-> !group0Enable && !secureGroup1EnBit && // R03
    !nonsecureGroup1EnBit) else $error("enable not cleared by reset");

  a_group0_write_lands: assert property (physWrG0 |=> group0Enable == $past(wrBit)) // R01
    else $error("group0 enable write lost");

  a_rdata_upper_zero: assert property (rspValid |-> rsp.rdata[31:2] == 30'h0000_0000) // R01
    else $error("reserved read bits not zero");

  a_virt_g0_route: assert property (reqValid && hitG0 && req.el == cigen_pkg::EL_1 && ns && // R10
    ctrl.hypFastIrqRouting && ctrl.sysregInterfaceEnable[0] && !ctrl.trapAllGroup0
    |=> rspValid && rsp.virt && !rsp.trap) else $error("group0 not redirected to virtual");

  a_virt_g0_keeps_phys: assert property (virtWrG0 |=> $stable(group0Enable) && // R04
    virtGroup0EnField == $past(wrBit)) else $error("virtual group0 write wrong target");

  a_virt_g1_field: assert property (virtWrG1 |=> virtGroup1EnField == $past(wrBit) && // R05
    $stable(secureGroup1EnBit) && $stable(nonsecureGroup1EnBit))
    else $error("virtual group1 write wrong target");

  a_retarget_group0: assert property ($fell(group0Enable) && hppiValid && !hppiGroup1 && // R06
    hppiOneOfN |=> retargetGroup0) else $error("group0 retarget missing");

  a_retarget_group1: assert property ($fell(nonsecureGroup1EnBit) && hppiValid && hppiGroup1 && // R07
    !hppiSecure && hppiOneOfN |=> retargetGroup1) else $error("group1 retarget missing");

  a_retarget_g1_secure: assert property ($fell(secureGroup1EnBit) && hppiValid && hppiGroup1 && // R07
    hppiSecure && hppiOneOfN |=> retargetGroup1) else $error("secure group1 retarget missing");

  a_top_alias_secure: assert property (physWrTop |=> secureGroup1EnBit == $past(req.wdata[1]) && // R08
    nonsecureGroup1EnBit == $past(req.wdata[0])) else $error("top-level alias broken");

  a_el3_ns_select: assert property (physWrG1 && req.el == cigen_pkg::EL_3 && ns // R09
    |=> nonsecureGroup1EnBit == $past(wrBit) && $stable(secureGroup1EnBit))
    else $error("wrong group1 copy selected");

  a_sre_trap_el2: assert property (reqValid && hitG1 && req.el == cigen_pkg::EL_2 && // R13
    !ctrl.sysregInterfaceEnable[1] |=> rsp.trap && rsp.trapEl == cigen_pkg::EL_2)
    else $error("interface enable trap missing");

  a_trap_all1: assert property (reqValid && hitG1 && req.el == cigen_pkg::EL_1 && ns && // R15
    ctrl.sysregInterfaceEnable[0] && ctrl.trapAllGroup1 |=> rsp.trap && rsp.trapEl == cigen_pkg::EL_2)
    else $error("trap-all group1 missing");

  a_el3_trap_g0: assert property (reqValid && hitG0 && req.el == cigen_pkg::EL_2 && HAS_EL3 && // R16
    ctrl.sysregInterfaceEnable[1] && ctrl.secureFastIrqRouting
    |=> rsp.trap && rsp.trapEl == cigen_pkg::EL_3) else $error("EL3 group0 trap missing");

  a_gate_group0: assert property (!group0Enable |=> !fiqSignal) // R18
    else $error("group0 signalled while disabled");

  a_gate_group1: assert property (!curGroup1 |=> !irqSignal) // R18
    else $error("group1 signalled while disabled");

  a_unknown_enc_trap: assert property (reqValid && !hitG0 && !hitG1 && !hitTop // R12
    |=> rspValid && rsp.trap && rsp.trapEl == cigen_pkg::EL_1) else $error("unknown encoding not trapped");

  c_virtual_write: cover property (virtWrG1);
  c_retarget: cover property (retargetGroup0 || retargetGroup1);
  c_el3_trap: cover property (rspValid && rsp.trap && rsp.trapEl == cigen_pkg::EL_3);
  c_group1_signal: cover property (irqSignal);

endmodule

// [core/cigen_pkg.sv]
// constants, field layouts and carrier types for the group enable block
// assumes one core clock domain and a synchronous active-high reset
package cigen_pkg;

  typedef logic [1:0] cigen_el_t;

  localparam cigen_el_t EL_0 = 2'h0;
  localparam cigen_el_t EL_1 = 2'h1;
  localparam cigen_el_t EL_2 = 2'h2;
  localparam cigen_el_t EL_3 = 2'h3;

  // op1, CRn, CRm, op2 packed in that order
  typedef struct packed {
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } cigen_enc_s;

  localparam logic [13:0] ENC_GROUP0 = 14'h0666;
  localparam logic [13:0] ENC_GROUP1 = 14'h0667;
  localparam logic [13:0] ENC_TOP_GROUP1 = 14'h3667;

  localparam int ENABLE_POS = 0;
  localparam int TOP_NS_POS = 0;
  localparam int TOP_S_POS = 1;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic write;
    cigen_el_t el;
    cigen_enc_s enc;
    logic [31:0] wdata;
  } cigen_req_s;

  typedef struct packed {
    logic trap;
    cigen_el_t trapEl;
    logic virt;
    logic [31:0] rdata;
  } cigen_rsp_s;

  // live control bits from the rest of the core
  typedef struct packed {
    logic nonsecureStateBit;
    logic secureFastIrqRouting;
    logic secureNormalIrqRouting;
    logic hypFastIrqRouting;
    logic hypNormalIrqRouting;
    logic trapAllGroup0;
    logic trapAllGroup1;
    logic [2:0] sysregInterfaceEnable;
  } cigen_ctrl_s;

  typedef struct packed {
    logic trap;
    cigen_el_t trapEl;
    logic virt;
  } cigen_route_s;

endpackage

// [core/cigen_retarget.sv]
// flags a 1-of-N retarget when an enable bit falls under a matching pending interrupt
// assumes the pending-interrupt info is current in the cycle of the fall
`timescale 1ns/1ps
module cigen_retarget (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic hppiMatch,
  output logic retarget
);

  logic enableDly;

  always_ff @(posedge clk) begin
    if (srst) begin
      enableDly <= cigen_pkg::ENABLE_RESET;
    end else begin
      enableDly <= enable;
    end
  end

  // R06 R07 retarget on fall
  always_ff @(posedge clk) begin
    if (srst) begin
      retarget <= 1'b0;
    end else begin
      retarget <= enableDly && !enable && hppiMatch;
    end
  end

endmodule

// [testbench/cigen_core_model.sv]
// core-side model that issues one system-register access at a time
// assumes the block answers on the edge that takes the request, one cycle after the request is driven
`timescale 1ns/1ps
module cigen_core_model (
  input wire logic clk,
  input wire logic srst,
  output logic reqValid,
  output cigen_pkg::cigen_req_s req,
  input wire logic rspValid,
  input wire cigen_pkg::cigen_rsp_s rsp
);
  initial begin
    reqValid = 1'h0;
    req = '0;
  end
  task automatic access(input logic w, input cigen_pkg::cigen_el_t el, input logic [13:0] enc,
      input logic [31:0] wd, output logic got, output cigen_pkg::cigen_rsp_s r);
    @(posedge clk);
    while (srst) @(posedge clk);
    reqValid <= 1'h1;
    req <= {w, el, enc, wd};
    @(posedge clk);
    reqValid <= 1'h0;
    // released write, encoding and data fields no longer show the last value; the level is kept
    req <= {~w, el, ~enc, ~wd};
    #1;
    got = rspValid;
    r = rsp;
  endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench for the group enable registers
// assumes the core model drives accesses; bench drives control and pending lines
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errorCnt++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic reqValid, rspValid, got;
  cigen_pkg::cigen_req_s req;
  cigen_pkg::cigen_rsp_s rsp, r;
  cigen_pkg::cigen_ctrl_s ctrl = '0;
  logic hppiValid = 1'h0, hppiGroup1 = 1'h0, hppiSecure = 1'h0, hppiOneOfN = 1'h0;
  logic pendGroup0 = 1'h0, pendGroup1 = 1'h0;
  logic group0Enable, secureGroup1EnBit, nonsecureGroup1EnBit, virtGroup0EnField, virtGroup1EnField;
  logic fiqSignal, irqSignal, retargetGroup0, retargetGroup1;
  int errorCnt = 0;
  int checked = 0;
  localparam logic [13:0] G0 = cigen_pkg::ENC_GROUP0;
  localparam logic [13:0] G1 = cigen_pkg::ENC_GROUP1;
  localparam logic [13:0] TOP = cigen_pkg::ENC_TOP_GROUP1;

  always #20 clk = ~clk;

  cigen_core_model cigen_core_model_i (.clk, .srst, .reqValid, .req, .rspValid, .rsp);
  cigen_group_enable_regs cigen_group_enable_regs_i (.clk, .srst, .reqValid, .req, .ctrl, .hppiValid,
    .hppiGroup1, .hppiSecure, .hppiOneOfN, .pendGroup0, .pendGroup1, .rspValid, .rsp, .group0Enable,
    .secureGroup1EnBit, .nonsecureGroup1EnBit, .virtGroup0EnField, .virtGroup1EnField, .fiqSignal,
    .irqSignal, .retargetGroup0, .retargetGroup1);

  task automatic acc(input logic w, input cigen_pkg::cigen_el_t el, input logic [13:0] enc, input logic [31:0] wd);
    cigen_core_model_i.access(w, el, enc, wd, got, r);
    `CHK(got, 1'h1)
  endtask

  // control bits: ns, sfiq, sirq, hfast, hnorm, trap_all_group0, trap_all_group1, sre[2:0]
  task automatic setc(input logic [9:0] c);
    @(posedge clk);
    ctrl <= cigen_pkg::cigen_ctrl_s'(c);
  endtask

  task automatic t_reset();
    `CHK({group0Enable, secureGroup1EnBit, nonsecureGroup1EnBit, virtGroup0EnField, virtGroup1EnField}, 5'h00)
    setc(10'h007);
    acc(1'h0, cigen_pkg::EL_1, G0, 32'h0000_0000);
    `CHK(r.rdata, 32'h0000_0000)
  endtask

  task automatic t_group0();
    acc(1'h1, cigen_pkg::EL_1, G0, 32'hFFFF_FFFF);
    `CHK({r.trap, group0Enable}, 2'h1)
    acc(1'h0, cigen_pkg::EL_1, G0, 32'h0000_0000);
    `CHK(r.rdata, 32'h0000_0001)
    acc(1'h1, cigen_pkg::EL_3, G0, 32'hFFFF_FFFE);
    `CHK(group0Enable, 1'h0)
  endtask

  task automatic t_group1();
    setc(10'h207);
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0001);
    `CHK({secureGroup1EnBit, nonsecureGroup1EnBit}, 2'h1)
    setc(10'h007);
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0001);
    `CHK({secureGroup1EnBit, nonsecureGroup1EnBit}, 2'h3)
    acc(1'h1, cigen_pkg::EL_3, TOP, 32'h0000_0001);
    `CHK({secureGroup1EnBit, nonsecureGroup1EnBit}, 2'h1)
    acc(1'h0, cigen_pkg::EL_1, G1, 32'h0000_0000);
    `CHK(r.rdata, 32'h0000_0000)
    setc(10'h207);
    acc(1'h0, cigen_pkg::EL_1, G1, 32'h0000_0000);
    `CHK(r.rdata, 32'h0000_0001)
    acc(1'h0, cigen_pkg::EL_3, TOP, 32'h0000_0000);
    `CHK(r.rdata, 32'h0000_0001)
    acc(1'h1, cigen_pkg::EL_3, TOP, 32'h0000_0000);
  endtask

  task automatic tcase(input logic [9:0] c, input cigen_pkg::cigen_el_t el, input logic [13:0] enc,
      input cigen_pkg::cigen_el_t exp);
    setc(c);
    acc(1'h1, el, enc, 32'h0000_0001);
    `CHK({r.trap, r.trapEl}, {1'h1, exp})
    `CHK({group0Enable, secureGroup1EnBit, nonsecureGroup1EnBit}, 3'h0)
  endtask

  task automatic t_traps();
    tcase(10'h006, cigen_pkg::EL_1, G0, cigen_pkg::EL_1);
    tcase(10'h005, cigen_pkg::EL_2, G1, cigen_pkg::EL_2);
    tcase(10'h003, cigen_pkg::EL_3, G1, cigen_pkg::EL_3);
    tcase(10'h217, cigen_pkg::EL_1, G0, cigen_pkg::EL_2);
    tcase(10'h20F, cigen_pkg::EL_1, G1, cigen_pkg::EL_2);
    tcase(10'h107, cigen_pkg::EL_2, G0, cigen_pkg::EL_3);
    tcase(10'h307, cigen_pkg::EL_1, G0, cigen_pkg::EL_3);
    tcase(10'h087, cigen_pkg::EL_1, G1, cigen_pkg::EL_3);
    tcase(10'h087, cigen_pkg::EL_2, G1, cigen_pkg::EL_3);
    tcase(10'h007, cigen_pkg::EL_1, 14'h0000, cigen_pkg::EL_1);
  endtask

  task automatic t_virtual();
    setc(10'h247);
    acc(1'h1, cigen_pkg::EL_1, G0, 32'h0000_0001);
    `CHK({r.trap, r.virt}, 2'h1)
    `CHK({virtGroup0EnField, group0Enable}, 2'h2)
    acc(1'h0, cigen_pkg::EL_1, G0, 32'h0000_0000);
    `CHK({r.virt, r.rdata}, {1'h1, 32'h0000_0001})
    setc(10'h227);
    acc(1'h1, cigen_pkg::EL_1, G1, 32'h0000_0001);
    `CHK({r.trap, r.virt}, 2'h1)
    `CHK({virtGroup1EnField, secureGroup1EnBit, nonsecureGroup1EnBit}, 3'h4)
    acc(1'h0, cigen_pkg::EL_1, G1, 32'h0000_0000);
    `CHK(r.rdata, 32'h0000_0001)
  endtask

  task automatic t_retarget();
    setc(10'h007);
    hppiValid <= 1'h1;
    hppiOneOfN <= 1'h1;
    acc(1'h1, cigen_pkg::EL_1, G0, 32'h0000_0001);
    acc(1'h1, cigen_pkg::EL_1, G0, 32'h0000_0000);
    @(posedge clk);
    #1;
    `CHK({retargetGroup0, retargetGroup1}, 2'h2)
    @(posedge clk);
    #1;
    `CHK(retargetGroup0, 1'h0)
    setc(10'h207);
    hppiGroup1 <= 1'h1;
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0001);
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0000);
    @(posedge clk);
    hppiOneOfN <= 1'h0;
    #1;
    `CHK({retargetGroup0, retargetGroup1}, 2'h1)
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0001);
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0000);
    @(posedge clk);
    #1;
    `CHK(retargetGroup1, 1'h0)
    // secure copy falling
    setc(10'h007);
    hppiSecure <= 1'h1;
    hppiOneOfN <= 1'h1;
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0001);
    acc(1'h1, cigen_pkg::EL_3, G1, 32'h0000_0000);
    @(posedge clk);
    hppiValid <= 1'h0;
    #1;
    `CHK({retargetGroup0, retargetGroup1}, 2'h1)
  endtask

  task automatic t_signal();
    setc(10'h007);
    pendGroup0 <= 1'h1;
    pendGroup1 <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({fiqSignal, irqSignal}, 2'h0)
    acc(1'h1, cigen_pkg::EL_1, G0, 32'h0000_0001);
    @(posedge clk);
    #1;
    `CHK({fiqSignal, irqSignal}, 2'h2)
    acc(1'h1, cigen_pkg::EL_1, G1, 32'h0000_0001);
    @(posedge clk);
    #1;
    `CHK({fiqSignal, irqSignal}, 2'h3)
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    #1;
    `CHK({group0Enable, secureGroup1EnBit, fiqSignal, irqSignal}, 4'h0)
  endtask

  task automatic stopTest();
    $display("checks %0d errors %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    #1;
    t_reset();
    t_group0();
    t_group1();
    t_traps();
    t_virtual();
    t_retarget();
    t_signal();
    stopTest();
  end

  initial begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    stopTest();
  end
endmodule
